// >>> logic/line_ctrl_pkg.sv
// constants shared by the line transceiver controller
// assumes a 100 MHz mclk and a transceiver driven through its logic pins
package line_ctrl_pkg;

  // ---------------------------------------------------------------
  // output configuration codes
  // ---------------------------------------------------------------
  localparam logic [1:0] CFG_SUPPLY_SIDE = 2'h0;
  localparam logic [1:0] CFG_GROUND_SIDE = 2'h1;
  localparam logic [1:0] CFG_PUSH_PULL   = 2'h2;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_IDENT  = 4'h2;

  // ---------------------------------------------------------------
  // control and status register fields
  // ---------------------------------------------------------------
  localparam int CTRL_DRIVE_BIT  = 0;
  localparam int CTRL_ENABLE_BIT = 1;
  localparam int CTRL_CFG_LSB    = 2;
  localparam int CTRL_PHASE_BIT  = 4;
  localparam int STAT_FAULT_BIT  = 0;
  localparam int STAT_RECV_BIT   = 1;
  localparam int STAT_BUSY_BIT   = 2;
  localparam int STAT_LOAD_BIT   = 3;
  localparam int STAT_VALID_BIT  = 4;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ         = 100;
  localparam int SETTLE_NS       = 2000;
  localparam int SETTLE_CYCLES   = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W           = 12;

  typedef enum logic [3:0] {
    ID_IDLE   = 4'h1,
    ID_FORCE  = 4'h2,
    ID_SETTLE = 4'h4,
    ID_SAMPLE = 4'h8
  } ident_state_t;

endpackage

// >>> logic/line_ctrl.sv
// controller for a 24 V line transceiver, driven through its logic pins
// assumes the transceiver pins are synchronous to mclk and pulled up externally
`timescale 1ns/1ps
`default_nettype none

module line_ctrl (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic      [7:0] rdata,
  output logic            primary_drive_input,
  output logic            secondary_drive_input,
  input  wire logic       enable_fault_pin_in,
  output logic            enable_fault_pin_out,
  output logic            enable_fault_pin_oe,
  input  wire logic       receiver_in
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0]                 ctrl_reg,  ctrl_next;
  logic [7:0]                 rdata_reg, rdata_next;
  logic                       prim_reg,  prim_next;
  logic                       sec_reg,   sec_next;
  logic                       en_reg,    en_next;
  logic                       oe_reg,    oe_next;
  logic                       load_reg,  load_next;
  logic                       valid_reg, valid_next;
  line_ctrl_pkg::ident_state_t id_reg,   id_next;
  logic [line_ctrl_pkg::CNT_W-1:0] cnt_reg, cnt_next;

  logic [1:0] cfg;
  logic       drive;
  logic       phase;
  logic       fault;

  assign cfg   = ctrl_reg[line_ctrl_pkg::CTRL_CFG_LSB +: 2];
  assign drive = ctrl_reg[line_ctrl_pkg::CTRL_DRIVE_BIT];
  assign phase = ctrl_reg[line_ctrl_pkg::CTRL_PHASE_BIT];
  // enable driven high yet pin reads low: device open drain active
  assign fault = en_reg & ~enable_fault_pin_in;

  // ---------------------------------------------------------------
  // register access and pin mapping
  // ---------------------------------------------------------------
  always_comb begin
    ctrl_next  = ctrl_reg;
    rdata_next = 8'h00;
    if (wr_stb && addr == line_ctrl_pkg::ADDR_CTRL) begin
      ctrl_next = wdata;
    end
    if (rd_stb) begin
      case (addr)
        line_ctrl_pkg::ADDR_CTRL: begin
          rdata_next = ctrl_reg;
        end
        line_ctrl_pkg::ADDR_STATUS: begin
          rdata_next[line_ctrl_pkg::STAT_FAULT_BIT] = fault;
          rdata_next[line_ctrl_pkg::STAT_RECV_BIT]  = receiver_in;
          rdata_next[line_ctrl_pkg::STAT_BUSY_BIT]  = (id_reg != line_ctrl_pkg::ID_IDLE);
          rdata_next[line_ctrl_pkg::STAT_LOAD_BIT]  = load_reg;
          rdata_next[line_ctrl_pkg::STAT_VALID_BIT] = valid_reg;
        end
        default: begin
          rdata_next = 8'h00;
        end
      endcase
    end
  end

  always_comb begin
    id_next    = id_reg;
    cnt_next   = cnt_reg;
    load_next  = load_reg;
    valid_next = valid_reg;
    en_next    = ctrl_reg[line_ctrl_pkg::CTRL_ENABLE_BIT];
    if (cfg == line_ctrl_pkg::CFG_PUSH_PULL) begin
      // push-pull: primary static as phase, drive on secondary
      prim_next = phase;
      sec_next  = drive;
    end else begin
      // single-switch configs: drive on primary, no delay added
      prim_next = drive;
      sec_next  = phase;
    end
    case (id_reg)
      line_ctrl_pkg::ID_IDLE: begin
        if (wr_stb && addr == line_ctrl_pkg::ADDR_IDENT) begin
          id_next    = line_ctrl_pkg::ID_FORCE;
          valid_next = 1'b0;
        end
      end
      line_ctrl_pkg::ID_FORCE: begin
        id_next  = line_ctrl_pkg::ID_SETTLE;
        cnt_next = line_ctrl_pkg::CNT_W'(line_ctrl_pkg::SETTLE_CYCLES - 1);
      end
      line_ctrl_pkg::ID_SETTLE: begin
        if (cnt_reg == '0) begin
          id_next = line_ctrl_pkg::ID_SAMPLE;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      line_ctrl_pkg::ID_SAMPLE: begin
        // receiver equals primary low: supply-side load
        load_next  = receiver_in;
        valid_next = 1'b1;
        id_next    = line_ctrl_pkg::ID_IDLE;
      end
      default: begin
        id_next = line_ctrl_pkg::ID_IDLE;
      end
    endcase
    if (id_reg != line_ctrl_pkg::ID_IDLE) begin
      // identification: enable forced low, primary held low
      en_next   = 1'b0;
      prim_next = 1'b0;
    end
    // open-drain style: drive only while enable is asserted low
    oe_next = ~en_next;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_reg  <= line_ctrl_pkg::CTRL_RESET;
      rdata_reg <= 8'h00;
      prim_reg  <= 1'b0;
      sec_reg   <= 1'b0;
      en_reg    <= 1'b0;
      oe_reg    <= 1'b1;
      load_reg  <= 1'b0;
      valid_reg <= 1'b0;
      id_reg    <= line_ctrl_pkg::ID_IDLE;
      cnt_reg   <= '0;
    end else begin
      ctrl_reg  <= ctrl_next;
      rdata_reg <= rdata_next;
      prim_reg  <= prim_next;
      sec_reg   <= sec_next;
      en_reg    <= en_next;
      oe_reg    <= oe_next;
      load_reg  <= load_next;
      valid_reg <= valid_next;
      id_reg    <= id_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign rdata                 = rdata_reg;
  assign primary_drive_input   = prim_reg;
  assign secondary_drive_input = sec_reg;
  assign enable_fault_pin_out  = en_reg;
  assign enable_fault_pin_oe   = oe_reg;

endmodule

`default_nettype wire

// >>> verif/line_ctrl_sva.sv
// checker for the pin sequencing of line_ctrl
// bound to line_ctrl, sees its ports only
`timescale 1ns/1ps
`default_nettype none
module line_ctrl_sva (
  input wire logic       mclk,
  input wire logic       sys_rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr_stb,
  input wire logic       primary_drive_input,
  input wire logic       secondary_drive_input,
  input wire logic       enable_fault_pin_out,
  input wire logic       enable_fault_pin_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire logic ctl_wr;
  assign ctl_wr = wr_stb && addr == line_ctrl_pkg::ADDR_CTRL;
  sequence forced_low;
    enable_fault_pin_oe && !enable_fault_pin_out && !primary_drive_input;
  endsequence
  sequence pins_pp;
    secondary_drive_input == $past(wdata[0], 2) && primary_drive_input == $past(wdata[4], 2);
  endsequence
  sequence pins_single;
    primary_drive_input == $past(wdata[0], 2) && secondary_drive_input == $past(wdata[4], 2);
  endsequence
  chk_ident_force_low:
    assert property (wr_stb && addr == 4'h2 |-> ##2 forced_low [*8])
    else $error("identification did not force pins low");
  chk_push_pull_map:
    assert property (ctl_wr && wdata[3:2] == 2'h2 |-> ##2 pins_pp)
    else $error("push-pull drive mapping wrong");
  chk_single_map:
    assert property (ctl_wr && wdata[3:2] < 2'h2 |-> ##2 pins_single)
    else $error("single-switch drive mapping wrong");
  chk_enable_release:
    assert property (ctl_wr && wdata[1] |-> ##2 !enable_fault_pin_oe)
    else $error("enable pin still pulled low");
endmodule
bind line_ctrl line_ctrl_sva i_line_ctrl_sva (.mclk(mclk), .sys_rst(sys_rst), .addr(addr),
  .wdata(wdata), .wr_stb(wr_stb), .primary_drive_input(primary_drive_input),
  .secondary_drive_input(secondary_drive_input), .enable_fault_pin_out(enable_fault_pin_out),
  .enable_fault_pin_oe(enable_fault_pin_oe));
`default_nettype wire

// >>> verif/xcvr_model.sv
// behavioural transceiver logic seen from its logic pins
// the bench resolves the enable pin level from all pull-downs
`timescale 1ns/1ps
`default_nettype none
module xcvr_model (
  input  wire logic primary_drive_input,
  input  wire logic secondary_drive_input,
  input  wire logic pin_level,
  input  wire logic load_gnd,
  input  wire logic fault,
  output logic      receiver_out,
  output logic      pin_pull_low
);
  logic line;
  // driven line when enabled, else the load's pull resistor
  assign line = (pin_level && !fault) ? (primary_drive_input ^ secondary_drive_input)
                                      : load_gnd;
  assign receiver_out = primary_drive_input ^ line;
  assign pin_pull_low = fault;
endmodule
`default_nettype wire

// >>> verif/line_ctrl_tb.sv
// bench for line_ctrl against a behavioural transceiver
// drives the register port, judges pins and status reads
`timescale 1ns/1ps
`default_nettype none
module line_ctrl_tb;
  logic mclk = 0, sys_rst = 1, wr_stb = 0, rd_stb = 0, load_gnd = 0, fault = 0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  wire logic [7:0] rdata;
  wire logic pri, sec, en_out, en_oe, recv, pull, pin;
  int err_count = 0, n_tests = 0;
  always #5 mclk = ~mclk;
  assign pin = !((en_oe && !en_out) || pull);
  line_ctrl i_line_ctrl (.mclk(mclk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .primary_drive_input(pri),
    .secondary_drive_input(sec), .enable_fault_pin_in(pin), .enable_fault_pin_out(en_out),
    .enable_fault_pin_oe(en_oe), .receiver_in(recv));
  xcvr_model i_xcvr_model (.primary_drive_input(pri), .secondary_drive_input(sec),
    .pin_level(pin), .load_gnd(load_gnd), .fault(fault), .receiver_out(recv),
    .pin_pull_low(pull));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] m);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 chk(rdata & m, exp);
  endtask
  task automatic t_reset;
    #1 chk({4'h0, en_oe, en_out, pri, sec}, 8'h08);
    rd(line_ctrl_pkg::ADDR_CTRL, line_ctrl_pkg::CTRL_RESET, 8'hFF);
    rd(4'hF, 8'h00, 8'hFF);
    $display("reset test done");
  endtask
  task automatic t_map;
    logic [1:0] e;
    for (int c = 0; c < 3; c++) begin
      for (int v = 0; v < 4; v++) begin
        wr(line_ctrl_pkg::ADDR_CTRL, {3'h0, v[1], c[1:0], 1'b1, v[0]});
        e = (c == 2) ? {v[1], v[0]} : {v[0], v[1]};
        repeat (4) @(posedge mclk);
        #1 chk({6'h0, pri, sec}, {6'h0, e});
        rd(line_ctrl_pkg::ADDR_STATUS, {6'h0, e[0], 1'b0}, 8'h03);
      end
    end
    $display("mapping test done");
  endtask
  task automatic t_ident;
    for (int g = 0; g < 2; g++) begin
      @(posedge mclk);
      load_gnd <= g[0];
      wr(line_ctrl_pkg::ADDR_CTRL, 8'h02);
      wr(line_ctrl_pkg::ADDR_IDENT, 8'h00);
      repeat (2) @(posedge mclk);
      #1 chk({5'h0, en_oe, en_out, pri}, 8'h04);
      rd(line_ctrl_pkg::ADDR_STATUS, 8'h04, 8'h14);
      repeat (208) @(posedge mclk);
      rd(line_ctrl_pkg::ADDR_STATUS, {3'h0, 1'b1, g[0], 3'h0}, 8'h1C);
    end
    $display("identify test done");
  endtask
  task automatic t_fault;
    wr(line_ctrl_pkg::ADDR_CTRL, 8'h02);
    @(posedge mclk);
    fault <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(line_ctrl_pkg::ADDR_STATUS, 8'h01, 8'h01);
    fault <= 1'b0;
    $display("fault test done");
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #100us;
    err_count++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset();
    t_map();
    t_ident();
    t_fault();
    print_verdict();
  end
endmodule
`default_nettype wire
